// *** hw/tcs_defs.svh ***
/*
 * Pointer addresses, bit positions, reset values and timing figures
 * of the temperature conversion sequencer. Included by bare name.
 */
`ifndef TCS_DEFS_SVH
`define TCS_DEFS_SVH
`define TCS_PTR_STATUS 8'h08
`define TCS_PTR_CFG1 8'h09
`define TCS_PTR_CFG2 8'h0A
`define TCS_PTR_RATE 8'h0B
`define TCS_PTR_ONESHOT 8'h0F
`define TCS_BUSY_BIT 7
`define TCS_SHUT_BIT 6
`define TCS_RANGE_BIT 2
`define TCS_RC_BIT 2
`define TCS_LOCAL_BIT 3
`define TCS_EXT1_BIT 4
`define TCS_EXT2_BIT 5
`define TCS_EXT3_BIT 6
`define TCS_CFG1_RST 8'h00
`define TCS_CFG1_MASK 8'h44
`define TCS_CFG2_RST_1 8'h1C
`define TCS_CFG2_RST_2 8'h3C
`define TCS_CFG2_RST_3 8'h7C
`define TCS_RATE_RST 8'h07
`define TCS_RATE_MASK 8'h07
`define TCS_CLK_MHZ 125
`define TCS_US_PER_MS 1000
`define TCS_START_FAST_US 100
`define TCS_START_SLOW_US 1000
`define TCS_LOCAL_CONV_MS 16
`define TCS_EXT_CONV_MS 32
`define TCS_IDLE_MAX_MS 16000
`define TCS_NO_CHAN 3'h4
`endif

// *** hw/tcs_pkg.sv ***
/*
 * Types of the temperature conversion sequencer.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package tcs_pkg;
	typedef enum logic [2:0] {
		ST_BOOT = 3'h0,
		ST_BOOT_WAIT = 3'h1,
		ST_PICK = 3'h2,
		ST_CONV = 3'h3,
		ST_IDLE = 3'h4,
		ST_SHUT = 3'h5
	} tcs_state_e;
	typedef logic [2:0] tcs_chan_t;
endpackage

// *** hw/tcs_regs.sv ***
/*
 * Pointer-addressed registers: status, two configuration registers,
 * conversion rate, and the one-shot strobe. Access arrives already
 * decoded from the two-wire serial front end.
 */
`timescale 1ns/1ns
`include "tcs_defs.svh"
module tcs_regs #(
	parameter int NUM_EXT = 3
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] reg_ptr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	input wire logic busy,
	output logic [7:0] reg_rdata,
	output logic [7:0] cfg1,
	output logic [7:0] cfg2,
	output logic [7:0] rate,
	output logic oneshot_wr
);
	// Enables the variant has, which is also its reset value
	function automatic logic [7:0] cfg2_full(input int n);
		unique case (n)
			1: return `TCS_CFG2_RST_1;
			2: return `TCS_CFG2_RST_2;
			default: return `TCS_CFG2_RST_3;
		endcase
	endfunction

	localparam logic [7:0] CFG2_MASK = cfg2_full(NUM_EXT);

	assign oneshot_wr = reg_wr && reg_ptr == `TCS_PTR_ONESHOT;

	// status takes no writes; reserved bits stay 0
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cfg1 <= `TCS_CFG1_RST;
			cfg2 <= CFG2_MASK;
			rate <= `TCS_RATE_RST;
		end else if (reg_wr) begin
			if (reg_ptr == `TCS_PTR_CFG1)
				cfg1 <= reg_wdata & `TCS_CFG1_MASK;
			if (reg_ptr == `TCS_PTR_CFG2)
				cfg2 <= reg_wdata & CFG2_MASK;
			if (reg_ptr == `TCS_PTR_RATE)
				rate <= reg_wdata & `TCS_RATE_MASK;
		end
	end

	// status holds busy in D7 only
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_ptr)
				`TCS_PTR_STATUS: reg_rdata <= {busy, 7'h00};
				`TCS_PTR_CFG1: reg_rdata <= cfg1;
				`TCS_PTR_CFG2: reg_rdata <= cfg2;
				`TCS_PTR_RATE: reg_rdata <= rate;
				default: reg_rdata <= 8'h00;
			endcase
		end
	end
endmodule

// *** hw/tcs_timer.sv ***
/*
 * Cycle countdown timer; done pulses load_val+1 cycles after load.
 * Assumes load_val of at least one.
 */
`timescale 1ns/1ns
module tcs_timer #(
	parameter int W = 32
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic load,
	input wire logic [W-1:0] load_val,
	output logic done
);
	logic [W-1:0] cnt;
	logic running;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt <= '0;
			running <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (load) begin
				cnt <= load_val;
				running <= 1'b1;
			end else if (running) begin
				cnt <= cnt - 1'b1;
				if (cnt == {{(W-1){1'b0}}, 1'b1}) begin
					running <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end
endmodule

// *** hw/tcs_top.sv ***
/*
 * Conversion sequencer of a multi-channel temperature monitor:
 * registers, channel walk, idle delay, shutdown and one-shot.
 * Assumes a serial front end that presents decoded pointer accesses
 * synchronous to clk, and an analog converter that follows
 * conv_active and conv_chan.
 */
// Operation
// - Status register at pointer 08h is read-only; writes ignored.
// - Status D7 reads 1 during conversion, other bits read 0.
// - Busy rises within 100us after power-up, about 1ms on dual.
// - Configuration register 1 at 09h is writable and readable.
// - Shutdown bit 0 means continuous conversion at programmed rate.
// - Setting shutdown finishes current sequence, then stops converting.
// - Clearing shutdown resumes continuous conversions.
// - In shutdown, a one-shot write starts one conversion sequence.
// - Range bit 2 selects standard or extended result format.
// - Configuration register 1 resets to 00h, run and standard range.
// - Configuration register 2 at 0Ah holds channel and correction enables.
// - Bit 2 enables series resistance correction on external channels.
// - Without correction, external conversions take half as long.
// - Bit 3 enables the local channel.
// - Bit 4 enables external channel 1.
// - Bit 5 enables external channel 2 on two and three channel parts.
// - Bit 6 enables external channel 3 on three channel parts only.
// - Order is local, ext 1, 2, 3, then idle delay, then repeat.
// - Disabled channels are skipped with no conversion.
// - Rate register at 0Bh sets only idle time, not conversion time.
// - One-shot during conversion is ignored; its data not stored.
// - Register 2 resets to 1Ch, 3Ch or 7Ch by channel count.
`timescale 1ns/1ns
`include "tcs_defs.svh"
module tcs_top #(
	parameter int NUM_EXT = 3,
	parameter int CYC_PER_MS = `TCS_CLK_MHZ * `TCS_US_PER_MS,
	parameter int START_FAST_CYC = `TCS_START_FAST_US * `TCS_CLK_MHZ,
	parameter int START_SLOW_CYC = `TCS_START_SLOW_US * `TCS_CLK_MHZ,
	parameter int LOCAL_CONV_MS = `TCS_LOCAL_CONV_MS,
	parameter int EXT_CONV_MS = `TCS_EXT_CONV_MS
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] reg_ptr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic busy,
	output logic conv_active,
	output logic [1:0] conv_chan,
	output logic ext_range,
	output logic series_res_corr_en,
	output logic shutdown_ctl
);
	localparam logic [31:0] LOCAL_CYC =
		32'(LOCAL_CONV_MS * CYC_PER_MS);
	localparam logic [31:0] EXT_CYC = 32'(EXT_CONV_MS * CYC_PER_MS);
	localparam logic [31:0] START_CYC =
		32'((NUM_EXT == 2) ? START_SLOW_CYC : START_FAST_CYC);

	tcs_pkg::tcs_state_e state;
	tcs_pkg::tcs_chan_t chan_ptr;
	tcs_pkg::tcs_chan_t pick;
	logic [7:0] cfg1;
	logic [7:0] cfg2;
	logic [7:0] rate;
	logic oneshot_wr;
	logic [3:0] chan_on;
	logic tmr_load;
	logic [31:0] tmr_val;
	logic tmr_done;
	logic pick_found;
	logic seq_begin;

	// First enabled channel at or after the pointer
	function automatic tcs_pkg::tcs_chan_t next_chan(
		input logic [3:0] on, input tcs_pkg::tcs_chan_t from);
		tcs_pkg::tcs_chan_t r;
		r = `TCS_NO_CHAN;
		for (int i = 3; i >= 0; i--) begin
			if (on[i] && 3'(i) >= from)
				r = 3'(i);
		end
		return r;
	endfunction

	// Conversion time of one channel
	function automatic logic [31:0] conv_cycles(
		input tcs_pkg::tcs_chan_t ch, input logic rc);
		if (ch == 3'h0)
			return LOCAL_CYC;
		else if (rc)
			return EXT_CYC;
		else
			return EXT_CYC >> 1;
	endfunction

	// Idle delay, halving with each rate code step
	function automatic logic [31:0] idle_cycles(input logic [2:0] code);
		logic [31:0] ms;
		ms = 32'(`TCS_IDLE_MAX_MS) >> code;
		return 32'(ms * 32'(CYC_PER_MS));
	endfunction

	tcs_regs #(
		.NUM_EXT(NUM_EXT)
	) u_regs (
		.clk(clk),
		.resetn(resetn),
		.reg_ptr(reg_ptr),
		.reg_wr(reg_wr),
		.reg_wdata(reg_wdata),
		.reg_rd(reg_rd),
		.busy(busy),
		.reg_rdata(reg_rdata),
		.cfg1(cfg1),
		.cfg2(cfg2),
		.rate(rate),
		.oneshot_wr(oneshot_wr)
	);

	tcs_timer #(
		.W(32)
	) u_timer (
		.clk(clk),
		.resetn(resetn),
		.load(tmr_load),
		.load_val(tmr_val),
		.done(tmr_done)
	);

	assign ext_range = cfg1[`TCS_RANGE_BIT];
	assign shutdown_ctl = cfg1[`TCS_SHUT_BIT];
	assign series_res_corr_en = cfg2[`TCS_RC_BIT];

	assign chan_on[0] = cfg2[`TCS_LOCAL_BIT];
	assign chan_on[1] = cfg2[`TCS_EXT1_BIT];
	assign chan_on[2] = cfg2[`TCS_EXT2_BIT] && NUM_EXT >= 2;
	assign chan_on[3] = cfg2[`TCS_EXT3_BIT] && NUM_EXT >= 3;

	assign pick = next_chan(chan_on, chan_ptr);
	assign pick_found = pick != `TCS_NO_CHAN;

	// Entry to the first pick of a sequence
	always_comb begin
		seq_begin = 1'b0;
		unique case (state)
			tcs_pkg::ST_BOOT_WAIT: seq_begin = tmr_done;
			tcs_pkg::ST_IDLE: seq_begin = tmr_done && !shutdown_ctl;
			tcs_pkg::ST_SHUT: seq_begin = !shutdown_ctl || oneshot_wr;
			default: seq_begin = 1'b0;
		endcase
	end

	// rate feeds only the idle load
	always_comb begin
		tmr_load = 1'b0;
		tmr_val = START_CYC;
		if (state == tcs_pkg::ST_BOOT) begin
			tmr_load = 1'b1;
		end else if (state == tcs_pkg::ST_PICK) begin
			if (pick_found) begin
				tmr_load = 1'b1;
				tmr_val = conv_cycles(pick, cfg2[`TCS_RC_BIT]);
			end else if (!shutdown_ctl) begin
				tmr_load = 1'b1;
				tmr_val = idle_cycles(rate[2:0]);
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state <= tcs_pkg::ST_BOOT;
		end else begin
			unique case (state)
				tcs_pkg::ST_BOOT: state <= tcs_pkg::ST_BOOT_WAIT;
				tcs_pkg::ST_BOOT_WAIT:
					if (seq_begin)
						state <= tcs_pkg::ST_PICK;
				tcs_pkg::ST_PICK:
					if (pick_found)
						state <= tcs_pkg::ST_CONV;
					else if (shutdown_ctl)
						state <= tcs_pkg::ST_SHUT;
					else
						state <= tcs_pkg::ST_IDLE;
				tcs_pkg::ST_CONV:
					if (tmr_done)
						state <= tcs_pkg::ST_PICK;
				tcs_pkg::ST_IDLE:
					if (shutdown_ctl)
						state <= tcs_pkg::ST_SHUT;
					else if (seq_begin)
						state <= tcs_pkg::ST_PICK;
				tcs_pkg::ST_SHUT:
					if (seq_begin)
						state <= tcs_pkg::ST_PICK;
				default: state <= tcs_pkg::ST_BOOT;
			endcase
		end
	end

	// Channel pointer walks upward through a sequence
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			chan_ptr <= 3'h0;
		end else if (seq_begin) begin
			chan_ptr <= 3'h0;
		end else if (state == tcs_pkg::ST_PICK && pick_found) begin
			chan_ptr <= pick + 3'h1;
		end
	end

	// Converter drive
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			conv_active <= 1'b0;
			conv_chan <= 2'h0;
		end else if (state == tcs_pkg::ST_PICK && pick_found) begin
			conv_active <= 1'b1;
			conv_chan <= pick[1:0];
		end else if (state == tcs_pkg::ST_CONV && tmr_done) begin
			conv_active <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			busy <= 1'b0;
		end else if (state == tcs_pkg::ST_PICK) begin
			busy <= pick_found;
		end
	end

	// Helper state for the checks below
	logic [31:0] up_cnt;
	logic boot_seen;
	logic [1:0] last_chan;
	logic in_seq;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			up_cnt <= 32'h0;
			boot_seen <= 1'b0;
		end else begin
			if (up_cnt != 32'hFFFFFFFF)
				up_cnt <= up_cnt + 32'h1;
			if (busy)
				boot_seen <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			last_chan <= 2'h0;
			in_seq <= 1'b0;
		end else if (seq_begin) begin
			in_seq <= 1'b0;
		end else if (state == tcs_pkg::ST_PICK && pick_found) begin
			last_chan <= pick[1:0];
			in_seq <= 1'b1;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	sequence s_oneshot_in_shut;
		state == tcs_pkg::ST_SHUT && oneshot_wr;
	endsequence

	sequence s_seq_started;
		state == tcs_pkg::ST_PICK;
	endsequence

	sequence s_conv_open;
		state == tcs_pkg::ST_CONV && !tmr_done;
	endsequence

	a_status_ro: assert property (
		reg_wr && reg_ptr == `TCS_PTR_STATUS
		|=> $stable(cfg1) && $stable(cfg2) && $stable(rate))
	else $error("status write changed a register");

	a_busy_conv: assert property (
		conv_active |-> busy)
	else $error("conversion without busy");

	a_boot_bound: assert property (
		up_cnt == START_CYC + 32'h4 && chan_on != 4'h0
		|-> boot_seen)
	else $error("busy late after power-up");

	a_cfg1_write: assert property (
		reg_wr && reg_ptr == `TCS_PTR_CFG1
		|=> shutdown_ctl == $past(reg_wdata[`TCS_SHUT_BIT]))
	else $error("shutdown bit not written");

	a_run_cont: assert property (
		state == tcs_pkg::ST_IDLE && tmr_done && !shutdown_ctl
		|=> s_seq_started)
	else $error("idle did not restart sequence");

	a_shut_finish: assert property (
		s_conv_open |=> state == tcs_pkg::ST_CONV)
	else $error("conversion cut short");

	a_resume: assert property (
		state == tcs_pkg::ST_SHUT && !shutdown_ctl |=> s_seq_started)
	else $error("no resume after shutdown cleared");

	a_oneshot_go: assert property (
		s_oneshot_in_shut |=> s_seq_started)
	else $error("one-shot did not start sequence");

	a_oneshot_busy: assert property (
		oneshot_wr && state == tcs_pkg::ST_CONV
		|=> state != tcs_pkg::ST_SHUT && $stable(cfg2))
	else $error("one-shot during conversion took effect");

	a_skip_off: assert property (
		$rose(conv_active) && $stable(cfg2) |-> chan_on[conv_chan])
	else $error("disabled channel converted");

	a_walk_order: assert property (
		state == tcs_pkg::ST_PICK && pick_found && in_seq
		|-> pick[1:0] > last_chan)
	else $error("channel order broken");

	a_rc_half: assert property (
		state == tcs_pkg::ST_PICK && pick_found && pick != 3'h0
		&& !cfg2[`TCS_RC_BIT] |-> tmr_val == (EXT_CYC >> 1))
	else $error("uncorrected conversion time wrong");

	a_busy_hold: assert property (
		state == tcs_pkg::ST_CONV && tmr_done
		|=> busy ##1 (state == tcs_pkg::ST_CONV) == busy)
	else $error("busy dropped inside sequence");
endmodule

// *** verification/tb_top.sv ***
/*
 * Self-checking bench of the conversion sequencer with shortened counts.
 * Assumes tcs_top and the host model; no other stimulus source.
 */
`timescale 1ns/1ns
module tb_top;
	localparam int CPM = 10;
	localparam int SFAST = 20;
	localparam int SSLOW = 40;
	localparam int LOC = 16 * CPM + 2;
	localparam int EXT = 32 * CPM + 2;
	localparam int IDLE = (16000 >> 7) * CPM;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] reg_ptr, reg_wdata, reg_rdata, v;
	logic reg_wr, reg_rd, busy, conv_active, ext_range;
	logic series_res_corr_en, shutdown_ctl;
	logic [1:0] conv_chan;
	logic [7:0] rdata2;
	logic busy2;
	logic up2 = 1'b0;
	int rise2 = 0;
	int err_count = 0;
	int samples_checked = 0;
	int n;
	always #4 clk = ~clk;
	tcs_top #(.NUM_EXT(3), .CYC_PER_MS(CPM), .START_FAST_CYC(SFAST),
		.START_SLOW_CYC(40), .LOCAL_CONV_MS(16), .EXT_CONV_MS(32)) dut_u (
		.clk(clk), .resetn(resetn), .reg_ptr(reg_ptr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.busy(busy), .conv_active(conv_active), .conv_chan(conv_chan),
		.ext_range(ext_range), .series_res_corr_en(series_res_corr_en),
		.shutdown_ctl(shutdown_ctl));
	tcs_host_model host_u (.clk(clk), .reg_ptr(reg_ptr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	// Dual-channel variant on the same host bus
	tcs_top #(.NUM_EXT(2), .CYC_PER_MS(CPM), .START_FAST_CYC(SFAST),
		.START_SLOW_CYC(SSLOW), .LOCAL_CONV_MS(16), .EXT_CONV_MS(32)) dut2_u (
		.clk(clk), .resetn(resetn), .reg_ptr(reg_ptr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(rdata2),
		.busy(busy2), .conv_active(), .conv_chan(), .ext_range(),
		.series_res_corr_en(), .shutdown_ctl());
	// Falling edges from release until the dual variant first goes busy
	always @(negedge clk) begin
		if (busy2 === 1'b1)
			up2 = 1'b1;
		else if (resetn && !up2)
			rise2++;
	end
	task automatic chk8(input string s, input logic [7:0] e,
		input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic chk_rng(input string s, input int lo, input int hi,
		input int g);
		samples_checked++;
		if (g < lo || g > hi) begin
			err_count++;
			$display("ERROR %s expected %0d..%0d seen %0d", s, lo, hi, g);
		end
	endtask
	// Falling edges until busy equals b, at most lim
	task automatic wait_busy(input logic b, input int lim, output int c);
		c = 0;
		while (busy !== b && c < lim) begin
			@(negedge clk);
			c++;
		end
	endtask
	// Follows cnt channel conversions, channel codes packed two bits each
	task automatic watch(input int cnt, input logic [7:0] chs, input int xl);
		int c;
		int k;
		int gap;
		logic [1:0] ch;
		for (int i = 0; i < cnt; i++) begin
			c = 0;
			gap = 0;
			ch = chs[2*i+:2];
			while (conv_active !== 1'b1 && c < 3000) begin
				if (busy !== 1'b1 && i > 0) gap = 1;
				@(negedge clk);
				c++;
			end
			chk_rng("busy_gap", 0, 0, gap);
			chk8("conv_chan", {6'h00, ch}, {6'h00, conv_chan});
			k = 0;
			while (conv_active === 1'b1 && k < 1000) begin
				@(negedge clk);
				k++;
			end
			c = (ch == 2'd0) ? LOC : xl;
			chk_rng("conv_len", c - 2, c + 2, k);
		end
		wait_busy(1'b0, 10, c);
		chk_rng("busy_fall", 0, 4, c);
	endtask
	task automatic t_boot();
		wait_busy(1'b1, 200, n);
		chk_rng("start_delay", SFAST, SFAST + 5, n);
		host_u.rd(8'h08, v);
		chk8("status", 8'h80, v);
		host_u.rd(8'h09, v);
		chk8("cfg1_reset", 8'h00, v);
		host_u.rd(8'h0A, v);
		chk8("cfg2_reset", 8'h7C, v);
		chk8("cfg2_dual", 8'h3C, rdata2);
		chk8("cfg_pins", 8'h02,
			{5'h00, ext_range, series_res_corr_en, shutdown_ctl});
	endtask
	task automatic t_seq();
		wait_busy(1'b0, 2000, n);
		chk_rng("start_dual", SSLOW + 2, SSLOW + 4, rise2);
		wait_busy(1'b1, 2000, n);
		chk_rng("idle_len", IDLE - 3, IDLE + 3, n);
		watch(4, {2'd3, 2'd2, 2'd1, 2'd0}, EXT);
	endtask
	task automatic t_skip();
		host_u.wr(8'h0A, 8'h50);
		host_u.rd(8'h0A, v);
		chk8("cfg2", 8'h50, v);
		chk8("cfg2_dual", 8'h10, rdata2);
		chk8("rc_pin", 8'h00, {7'h00, series_res_corr_en});
		watch(2, {4'h0, 2'd3, 2'd1}, 16 * CPM + 2);
		host_u.wr(8'h0A, 8'h2C);
		watch(2, {4'h0, 2'd2, 2'd0}, EXT);
	endtask
	task automatic t_shut();
		wait_busy(1'b1, 2000, n);
		host_u.wr(8'h09, 8'h40);
		chk8("sd_pin", 8'h01, {7'h00, shutdown_ctl});
		wait_busy(1'b0, 1000, n);
		chk_rng("seq_finish", LOC + EXT - 12, LOC + EXT + 6, n);
		wait_busy(1'b1, 1500, n);
		chk_rng("shut_quiet", 1500, 1500, n);
		host_u.wr(8'h0F, 8'hAA);
		wait_busy(1'b1, 10, n);
		chk_rng("oneshot_start", 0, 6, n);
		host_u.wr(8'h0F, 8'h55);
		wait_busy(1'b0, 1000, n);
		wait_busy(1'b1, 1500, n);
		chk_rng("oneshot_busy", 1500, 1500, n);
		host_u.wr(8'h09, 8'h00);
		wait_busy(1'b1, 10, n);
		chk_rng("resume", 0, 6, n);
	endtask
	task automatic t_regs();
		host_u.wr(8'h08, 8'hFF);
		host_u.rd(8'h08, v);
		chk8("status_ro", 8'h80, v);
		host_u.wr(8'h09, 8'h04);
		host_u.rd(8'h09, v);
		chk8("cfg1", 8'h04, v);
		chk8("range_pin", 8'h01, {7'h00, ext_range});
		host_u.rd(8'h30, v);
		chk8("unmapped", 8'h00, v);
		host_u.wr(8'h09, 8'h00);
		host_u.wr(8'h0B, 8'h06);
		host_u.rd(8'h0B, v);
		chk8("rate", 8'h06, v);
		wait_busy(1'b0, 1000, n);
		wait_busy(1'b1, 3000, n);
		chk_rng("idle_rate", 2 * IDLE - 3, 2 * IDLE + 3, n);
		watch(2, {4'h0, 2'h2, 2'h0}, EXT);
	endtask
	task automatic end_of_test();
		$display("Checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk);
		@(negedge clk);
		resetn = 1'b1;
		t_boot();
		$display("t_boot done");
		t_seq();
		$display("t_seq done");
		t_skip();
		$display("t_skip done");
		t_shut();
		$display("t_shut done");
		t_regs();
		$display("t_regs done");
		end_of_test();
	end
	// Roughly four times the expected run length
	initial begin
		#(60000 * 8);
		err_count++;
		$display("ERROR watchdog expected finish seen hang");
		end_of_test();
	end
endmodule

// *** verification/tcs_host_model.sv ***
/*
 * Host side model: single-byte pointer writes and reads.
 * Assumes the tcs_top register port; drives at the falling edge.
 */
`timescale 1ns/1ns
module tcs_host_model (
	input wire logic clk,
	output logic [7:0] reg_ptr,
	output logic reg_wr,
	output logic [7:0] reg_wdata,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata
);
	initial begin
		reg_ptr = 8'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
		reg_rd = 1'b0;
	end
	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		@(negedge clk);
		reg_ptr = p;
		reg_wdata = (p == 8'h09) ? (d & 8'h44) : d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
		// Released data no longer holds the last value
		reg_wdata = ~reg_wdata;
	endtask
	task automatic rd(input logic [7:0] p, output logic [7:0] d);
		@(negedge clk);
		reg_ptr = p;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		d = reg_rdata;
	endtask
endmodule
